// >>> verilog/agsf_status.sv
// conversion group status flags with an axi4-lite register slave
// Operation
// [R1] status bits 15-14 and 7-3 read zero; writes to them ignored
// [R2] bit 13 reads 1 while group 1 converting or frozen
// [R3] group in continuous mode reads busy throughout
// [R4] bit 12 reads 1 while group 2 converting or frozen
// [R5] bit 11 reads 1 while event group converting or frozen
// [R6] bit 10 reads 1 while group 1 frozen by arbitration
// [R7] bit 9 reads 1 while group 2 frozen by arbitration
// [R8] bit 8 reads 1 while event group frozen by arbitration
// [R9] busy and frozen flags read-only, reset zero, writes ignored
// [R10] bit 2 set when group 1 sequence finishes all channels
// [R11] reading a result of a group 1 channel clears bit 2
// [R12] any write to group 1 channel select clears bit 2
// [R13] writing 1 to bit 2 clears it; writing 0 ignored
// [R14] converter disabled holds bit 2 cleared
// [R15] irq enable and bit 2 set raise interrupt request
// [R16] set done flag never blocks result writes
// [R17] status register identical in both operating modes
// [R18] higher group finishing clears group 2 frozen, resumes it
// [R19] frozen flag set implies busy flag set
//
// Design decision made here: the AXI4-Lite register port.
`include "agsf_map.svh"
module agsf_status (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`AGSF_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`AGSF_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic buffered_mode,
	input wire logic [2:0] seq_start,
	input wire logic [2:0] seq_done,
	input wire logic [2:0] seq_freeze,
	input wire logic [2:0] cont_mode,
	input wire logic result_wr,
	input wire logic [3:0] result_ch,
	input wire logic [`AGSF_RES_W-1:0] result_data,
	output logic converter_enable,
	output logic [15:0] first_group_channel_select,
	output logic [2:0] seq_resume,
	output logic first_group_irq
);
	localparam int G1 = int'(agsf_pkg::AGSF_G1);
	localparam int G2 = int'(agsf_pkg::AGSF_G2);
	localparam int EV = int'(agsf_pkg::AGSF_EV);

	logic aw_full_reg;
	logic [`AGSF_ADDR_W-1:0] aw_addr_reg;
	logic w_full_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic rd_stat_reg;
	logic en_reg;
	logic irq_en_reg;
	agsf_pkg::agsf_half_type chsel_reg;
	logic done_reg;
	logic done_next;
	logic irq_reg;
	logic [2:0] busy_reg;
	logic [2:0] susp_reg;
	logic [2:0] resume_reg;
	logic [`AGSF_RES_W-1:0] res_reg [`AGSF_NCHAN];

	// address decode and strobes
	wire do_wr = aw_full_reg & w_full_reg & ~bvalid_reg;
	wire ar_take = s_axi_arvalid & ~rvalid_reg;
	wire wr_ctrl = do_wr & (aw_addr_reg == `AGSF_CTRL_OFS);
	wire wr_chsel = do_wr & (aw_addr_reg == `AGSF_CHSEL_OFS);
	wire wr_stat = do_wr & (aw_addr_reg == `AGSF_STAT_OFS);
	wire wr_res = do_wr &
		(aw_addr_reg[`AGSF_RES_MSB:`AGSF_RES_LSB] == `AGSF_RES_TAG) &
		(aw_addr_reg[1:0] == 2'h0);
	wire wr_hit = wr_ctrl | wr_chsel | wr_stat | wr_res;
	wire rd_ctrl = s_axi_araddr == `AGSF_CTRL_OFS;
	wire rd_chsel = s_axi_araddr == `AGSF_CHSEL_OFS;
	wire rd_stat = s_axi_araddr == `AGSF_STAT_OFS;
	wire rd_res = (s_axi_araddr[`AGSF_RES_MSB:`AGSF_RES_LSB] ==
		`AGSF_RES_TAG) & (s_axi_araddr[1:0] == 2'h0);
	wire [3:0] rd_ch = s_axi_araddr[5:2];
	wire rd_hit = rd_ctrl | rd_chsel | rd_stat | rd_res;

	// the same word is built in either operating mode
	wire [2:0] active = busy_reg | susp_reg | cont_mode; // R2 R3 R4 R5 R19 R17
	wire [15:0] stat_word = {2'h0, // R1
		active[G1], active[G2], active[EV],
		susp_reg[G1], susp_reg[G2], susp_reg[EV], // R6 R7 R8
		5'h00, done_reg, 2'h0}; // R1
	wire [31:0] ctrl_word = {30'h0, irq_en_reg, en_reg};
	wire [31:0] rd_word = rd_stat ? {16'h0000, stat_word} :
		rd_ctrl ? ctrl_word :
		rd_chsel ? {16'h0000, chsel_reg} :
		rd_res ? {22'h0, res_reg[rd_ch]} : 32'h0000_0000;

	// done flag set and clear sources
	wire rd_g1_result = ar_take & rd_res & chsel_reg[rd_ch]; // R11
	wire sw_clr = wr_stat & w_strb_reg[0] &
		w_data_reg[`AGSF_STAT_DONE_BIT]; // R13
	wire done_set = seq_done[G1] & en_reg; // R10
	wire done_clr = rd_g1_result | wr_chsel | sw_clr; // R12

	// a new completion wins over a clear in the same cycle
	always_comb begin
		done_next = done_reg;
		if (done_clr)
			done_next = 1'b0;
		if (done_set)
			done_next = 1'b1; // R10
		if (!en_reg)
			done_next = 1'b0; // R14
	end

	assign s_axi_awready = ~aw_full_reg;
	assign s_axi_wready = ~w_full_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = ~rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign converter_enable = en_reg;
	assign first_group_channel_select = chsel_reg;
	assign seq_resume = resume_reg;
	assign first_group_irq = irq_reg;

	// write address and data are caught in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_full_reg <= 1'b0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
		end else begin
			if (s_axi_awvalid & ~aw_full_reg) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end else if (do_wr) begin
				aw_full_reg <= 1'b0;
			end
			if (s_axi_wvalid & ~w_full_reg) begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end else if (do_wr) begin
				w_full_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= `AGSF_RESP_OKAY;
		end else if (do_wr) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= wr_hit ? `AGSF_RESP_OKAY : `AGSF_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= `AGSF_RESP_OKAY;
			rd_stat_reg <= 1'b0;
		end else if (ar_take) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_word;
			rresp_reg <= rd_hit ? `AGSF_RESP_OKAY : `AGSF_RESP_SLVERR;
			rd_stat_reg <= rd_stat;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// software registers; result words are read-only and ignore writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en_reg <= 1'b0;
			irq_en_reg <= 1'b0;
			chsel_reg <= `AGSF_CHSEL_RST;
		end else begin
			if (wr_ctrl & w_strb_reg[0]) begin
				en_reg <= w_data_reg[`AGSF_CTRL_EN_BIT];
				irq_en_reg <= w_data_reg[`AGSF_CTRL_IRQEN_BIT];
			end
			if (wr_chsel & w_strb_reg[0])
				chsel_reg[7:0] <= w_data_reg[7:0];
			if (wr_chsel & w_strb_reg[1])
				chsel_reg[15:8] <= w_data_reg[15:8];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			done_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			done_reg <= done_next;
			irq_reg <= done_reg & irq_en_reg; // R15
		end
	end

	// results are stored whatever the done flag says
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < `AGSF_NCHAN; i++)
				res_reg[i] <= 10'h000;
		end else if (result_wr) begin
			res_reg[result_ch] <= result_data; // R16
		end
	end

	// per group busy and frozen flags, only the sequencer moves them
	genvar g;
	generate
		for (g = 0; g < `AGSF_NGRP; g++) begin : grp
			wire others_done = |(seq_done & ~(3'h1 << g));
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					busy_reg[g] <= 1'b0; // R9
					susp_reg[g] <= 1'b0;
					resume_reg[g] <= 1'b0;
				end else begin
					busy_reg[g] <= seq_start[g] |
						(busy_reg[g] & ~seq_done[g]);
					susp_reg[g] <= seq_freeze[g] |
						(susp_reg[g] & ~others_done); // R18
					resume_reg[g] <= susp_reg[g] & others_done &
						~seq_freeze[g]; // R18
				end
			end
		end
	endgenerate

	property p_reserved_zero;
		@(posedge aclk) disable iff (!aresetn)
		rvalid_reg && rd_stat_reg |->
			rdata_reg[31:14] == 18'h0 && rdata_reg[7:3] == 5'h00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) // R1
		else $error("status reserved bits not zero");

	property p_first_group_active_flag;
		@(posedge aclk) disable iff (!aresetn)
		seq_start[G1] |=> stat_word[13];
	endproperty
	a_first_group_active_flag: assert property (p_first_group_active_flag) // R2
		else $error("group 1 busy missing after start");

	property p_cont_busy;
		@(posedge aclk) disable iff (!aresetn)
		cont_mode[G2] |-> stat_word[12];
	endproperty
	a_cont_busy: assert property (p_cont_busy) // R3
		else $error("continuous group 2 not busy");

	property p_susp_busy;
		@(posedge aclk) disable iff (!aresetn)
		stat_word[10] |-> stat_word[13];
	endproperty
	a_susp_busy: assert property (p_susp_busy) // R19
		else $error("frozen group 1 not busy");

	sequence s_g1_finish;
		seq_done[G1] && en_reg && !(wr_chsel || rd_g1_result);
	endsequence
	property p_done_set;
		@(posedge aclk) disable iff (!aresetn)
		s_g1_finish ##1 en_reg |-> done_reg;
	endproperty
	a_done_set: assert property (p_done_set) // R10
		else $error("group 1 done flag not set");

	property p_chsel_clear;
		@(posedge aclk) disable iff (!aresetn)
		wr_chsel && !seq_done[G1] |=> !done_reg;
	endproperty
	a_chsel_clear: assert property (p_chsel_clear) // R12
		else $error("channel select write did not clear done");

	property p_w1c;
		@(posedge aclk) disable iff (!aresetn)
		sw_clr && !seq_done[G1] |=> !done_reg;
	endproperty
	a_w1c: assert property (p_w1c) // R13
		else $error("write one did not clear done");

	property p_disabled_clear;
		@(posedge aclk) disable iff (!aresetn)
		!en_reg |=> !done_reg;
	endproperty
	a_disabled_clear: assert property (p_disabled_clear) // R14
		else $error("done flag set while disabled");

	property p_irq;
		@(posedge aclk) disable iff (!aresetn)
		done_reg && irq_en_reg |=> first_group_irq;
	endproperty
	a_irq: assert property (p_irq) // R15
		else $error("group 1 interrupt not raised");

	sequence s_g2_frozen_release;
		susp_reg[G2] && (seq_done[G1] || seq_done[EV]) &&
			!seq_freeze[G2];
	endsequence
	property p_g2_resume;
		@(posedge aclk) disable iff (!aresetn)
		s_g2_frozen_release |=> !stat_word[9] && seq_resume[G2];
	endproperty
	a_g2_resume: assert property (p_g2_resume) // R18
		else $error("group 2 not resumed after higher group");
endmodule // agsf_status

// >>> verilog/agsf_map.svh
// register offsets, field positions and reset values of the status block
`ifndef AGSF_MAP_SVH
`define AGSF_MAP_SVH
`define AGSF_ADDR_W 8
`define AGSF_CTRL_OFS 8'h00
`define AGSF_CHSEL_OFS 8'h04
`define AGSF_STAT_OFS 8'h08
`define AGSF_RES_BASE 8'h40
`define AGSF_RES_MSB 7
`define AGSF_RES_LSB 6
`define AGSF_RES_TAG 2'h1
`define AGSF_NCHAN 16
`define AGSF_RES_W 10
`define AGSF_NGRP 3
`define AGSF_CTRL_EN_BIT 0
`define AGSF_CTRL_IRQEN_BIT 1
`define AGSF_STAT_DONE_BIT 2
`define AGSF_STAT_RST 16'h0000
`define AGSF_CHSEL_RST 16'h0000
`define AGSF_RESP_OKAY 2'h0
`define AGSF_RESP_SLVERR 2'h2
`endif

// >>> verilog/agsf_pkg.sv
// types shared by the status block
package agsf_pkg;
	// group index: first, second, event
	typedef enum logic [1:0] {
		AGSF_G1 = 2'h0,
		AGSF_G2 = 2'h1,
		AGSF_EV = 2'h2
	} agsf_group_type;
	typedef logic [15:0] agsf_half_type;
endpackage

// >>> test/tb_top.sv
// self-checking bench for the conversion group status block
`include "agsf_map.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [2:0] st, fr, dn, cm;
		logic [15:0] stat;
		logic irq;
		logic [2:0] rs;
	} agsf_row_type;
	logic [2:0] rsm;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [`AGSF_ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hF, result_ch = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, buffered_mode = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, converter_enable, first_group_irq, result_wr = 1'b0;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [1:0] ok_resp = `AGSF_RESP_OKAY;
	logic [2:0] seq_start = 3'h0, seq_done = 3'h0, seq_freeze = 3'h0;
	logic [2:0] cont_mode = 3'h0, seq_resume;
	logic [`AGSF_RES_W-1:0] result_data = 10'h000;
	logic [15:0] first_group_channel_select;
	int n_mismatch = 0, total_checks = 0, cycles = 0;
	agsf_row_type g1_done = '{3'h0, 3'h0, 3'h1, 3'h0, 16'h0000, 1'b0, 3'h0};
	agsf_row_type rows [11] = '{
		'{3'h1, 3'h0, 3'h0, 3'h0, 16'h2000, 1'b0, 3'h0},
		'{3'h2, 3'h0, 3'h0, 3'h0, 16'h3000, 1'b0, 3'h0},
		'{3'h0, 3'h2, 3'h0, 3'h0, 16'h3200, 1'b0, 3'h0},
		'{3'h0, 3'h0, 3'h1, 3'h0, 16'h1004, 1'b1, 3'h2},
		'{3'h4, 3'h0, 3'h0, 3'h0, 16'h1804, 1'b1, 3'h0},
		'{3'h0, 3'h4, 3'h0, 3'h0, 16'h1904, 1'b1, 3'h0},
		'{3'h1, 3'h1, 3'h0, 3'h0, 16'h3D04, 1'b1, 3'h0},
		'{3'h0, 3'h0, 3'h6, 3'h0, 16'h2004, 1'b1, 3'h5},
		'{3'h0, 3'h0, 3'h1, 3'h0, 16'h0004, 1'b1, 3'h0},
		'{3'h0, 3'h0, 3'h0, 3'h7, 16'h3804, 1'b1, 3'h0},
		'{3'h0, 3'h0, 3'h0, 3'h0, 16'h0004, 1'b1, 3'h0}
	};
	agsf_status agsf_status_i (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .buffered_mode, .seq_start, .seq_done,
		.seq_freeze, .cont_mode, .result_wr, .result_ch, .result_data,
		.converter_enable, .first_group_channel_select, .seq_resume,
		.first_group_irq
	);
	always #25 aclk = ~aclk;
	task test_done();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_mismatch++;
			test_done();
		end
	end
	task chk_word(input string what, input logic [31:0] exp, got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task chk_resp(input string what, input logic [1:0] exp, got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// both channels offered together, each released once taken
	task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic pa, pw, ta, tw;
		pa = 1'b1;
		pw = 1'b1;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (pa || pw) begin
			@(negedge aclk);
			ta = pa && s_axi_awready === 1'b1;
			tw = pw && s_axi_wready === 1'b1;
			@(posedge aclk);
			if (ta) begin
				pa = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (tw) begin
				pw = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
		chk_resp("bresp", er, s_axi_bresp);
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask
	task axi_rd(input logic [7:0] a, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge aclk); while (s_axi_arready !== 1'b1);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		chk_resp("rresp", er, s_axi_rresp);
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		axi_rd(a, ok_resp);
		chk_word("rdata", exp, rd);
	endtask
	task irq_chk(input logic e);
		@(negedge aclk);
		chk_word("irq", {31'h0, e}, {31'h0, first_group_irq});
	endtask
	// start, freeze and done pulses in successive cycles
	task seq(input agsf_row_type r);
		@(posedge aclk);
		seq_start <= r.st;
		cont_mode <= r.cm;
		@(posedge aclk);
		seq_start <= 3'h0;
		seq_freeze <= r.fr;
		@(posedge aclk);
		seq_freeze <= 3'h0;
		seq_done <= r.dn;
		@(posedge aclk);
		seq_done <= 3'h0;
		// resume pulse stands for the cycle after the done edge
		@(negedge aclk);
		rsm = seq_resume;
	endtask
	task do_reset();
		aresetn <= 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
	endtask
	initial begin
		do_reset();
		rd_chk(`AGSF_STAT_OFS, 32'h0);
		rd_chk(`AGSF_CTRL_OFS, 32'h0);
		rd_chk(`AGSF_CHSEL_OFS, 32'h0);
		$display("test reset done");
		axi_wr(`AGSF_CTRL_OFS, 32'h3, ok_resp);
		rd_chk(`AGSF_CTRL_OFS, 32'h3);
		chk_word("converter_enable", 32'h1, {31'h0, converter_enable});
		foreach (rows[i]) begin
			seq(rows[i]);
			chk_word("seq_resume", {29'h0, rows[i].rs}, {29'h0, rsm});
			rd_chk(`AGSF_STAT_OFS, {16'h0, rows[i].stat});
			irq_chk(rows[i].irq);
		end
		$display("test rows done");
		axi_wr(`AGSF_STAT_OFS, 32'h0, ok_resp);
		rd_chk(`AGSF_STAT_OFS, 32'h4);
		axi_wr(`AGSF_STAT_OFS, 32'hFFFF_FFFF, ok_resp);
		rd_chk(`AGSF_STAT_OFS, 32'h0);
		irq_chk(1'b0);
		$display("test clear by write done");
		seq(g1_done);
		axi_wr(`AGSF_CHSEL_OFS, 32'h1, ok_resp);
		rd_chk(`AGSF_STAT_OFS, 32'h0);
		chk_word("chsel", 32'h1, {16'h0, first_group_channel_select});
		rd_chk(`AGSF_CHSEL_OFS, 32'h1);
		$display("test select write done");
		buffered_mode <= 1'b1;
		seq(g1_done);
		@(posedge aclk);
		result_wr <= 1'b1;
		result_data <= 10'h155;
		@(posedge aclk);
		result_wr <= 1'b0;
		rd_chk(`AGSF_RES_BASE + 8'h0C, 32'h0);
		rd_chk(`AGSF_STAT_OFS, 32'h4);
		rd_chk(`AGSF_RES_BASE, 32'h155);
		rd_chk(`AGSF_STAT_OFS, 32'h0);
		$display("test result read done");
		seq(g1_done);
		axi_wr(`AGSF_CTRL_OFS, 32'h2, ok_resp);
		rd_chk(`AGSF_STAT_OFS, 32'h0);
		chk_word("converter_enable", 32'h0, {31'h0, converter_enable});
		seq(g1_done);
		rd_chk(`AGSF_STAT_OFS, 32'h0);
		$display("test disabled done");
		axi_wr(`AGSF_CTRL_OFS, 32'h1, ok_resp);
		seq(g1_done);
		rd_chk(`AGSF_STAT_OFS, 32'h4);
		irq_chk(1'b0);
		$display("test irq off done");
		axi_rd(8'h20, `AGSF_RESP_SLVERR);
		chk_word("rdata", 32'h0, rd);
		axi_wr(8'h20, 32'h4, `AGSF_RESP_SLVERR);
		rd_chk(`AGSF_STAT_OFS, 32'h4);
		$display("test unmapped done");
		seq(rows[0]);
		@(posedge aclk);
		do_reset();
		rd_chk(`AGSF_STAT_OFS, 32'h0);
		rd_chk(`AGSF_CTRL_OFS, 32'h0);
		$display("test second reset done");
		test_done();
	end
endmodule // tb_top
